// ### shared/rpm_pkg.sv
// package of register offsets, field positions, reset values and timings for reset/power control
package rpm_pkg;
   localparam logic [7:0] int_enable_0_offset = 8'h30;
   localparam logic [7:0] interrupt_enable_1_offset = 8'h31;
   localparam logic [7:0] int_status_1_rd_offset = 8'h41;
   localparam logic [7:0] int_status_1_offset = 8'h44;
   localparam logic [7:0] internal_osc_control_offset = 8'h50;
   localparam logic [7:0] system_clock_select_offset = 8'h51;
   localparam logic [7:0] misc_control_offset = 8'h52;
   localparam logic [7:0] power_state_offset = 8'h53;
   localparam int reset_done_bit = 4;
   localparam int timer1_bit = 3;
   localparam int timer0_bit = 2;
   localparam int rtc_fail_bit = 3;
   localparam int clock_pin_override_bit = 2;
   localparam logic [7:0] ie1_fixed_mask = 8'he3;
   localparam logic [7:0] ie1_reset = 8'hff;
   localparam logic [7:0] ie0_reset = 8'hd7;
   localparam logic [7:0] osc_sync_value = 8'h07;
   localparam logic [7:0] osc_pin_value = 8'h03;
   localparam logic [7:0] osc_keep_value = 8'h06;
   localparam logic [7:0] osc_reset = 8'h06;
   localparam logic [7:0] clksel_rtc_value = 8'h05;
   localparam logic [7:0] clksel_reset = 8'h00;
   localparam logic [7:0] misc_reset = 8'h00;
   localparam int clk_mhz = 100;
   localparam int startup_delay_us = 100;
   localparam int startup_cycles = startup_delay_us * clk_mhz;
   localparam int power_on_release_delay_us = 300;
   localparam int power_on_cycles = power_on_release_delay_us * clk_mhz;
   localparam int reset_pulse_min_us = 15;
   localparam int reset_pulse_cycles = reset_pulse_min_us * clk_mhz;
   typedef enum logic [2:0] {st_por, st_pin_reset, st_startup, st_normal,
      st_sync, st_armed, st_preserve} pm_state_type;
endpackage : rpm_pkg

// ### logic/rpm_sync.sv
// two-flop synchroniser for pin inputs
module rpm_sync (
   input wire logic clk_i, // system clock
   input wire logic resetn_i, // async reset, active low
   input wire logic d_i, // asynchronous level
   output logic q_o // synchronised level
);
   logic meta;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta <= 1'b1;
         q_o <= 1'b1;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule : rpm_sync

// ### logic/reset_power_mode_control.sv
// reset sequencing, interrupt enable/status and ram preservation mode control
module reset_power_mode_control
   import rpm_pkg::*;
#(
   parameter int startup_count = startup_cycles, // start-up delay in cycles
   parameter int power_on_count = power_on_cycles, // power-on release delay in cycles
   parameter int reset_pulse_count = reset_pulse_cycles // least reset pin low time
) (
   input wire logic clk_i, // system clock 100 MHz
   input wire logic resetn_i, // async reset, active low
   input wire logic supply_good_i, // supply above threshold, asynchronous
   input wire logic ext_resetn_i, // external reset pin, active low, asynchronous
   input wire logic clock_pin_i, // clock pin level, asynchronous
   input wire logic timer0_event_i, // timer 0 overflow pulse
   input wire logic timer1_event_i, // timer 1 overflow or capture pulse
   input wire logic [7:0] avs_address, // register address
   input wire logic avs_read, // read strobe
   input wire logic avs_write, // write strobe
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte enables
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // wait request
   output logic int_n_o, // host interrupt pin, active low
   output logic gpio_release_o, // 1: gpio high impedance with weak pull-up
   output logic in_reset_o, // device in reset state
   output logic int_osc_enable_o, // internal oscillator run
   output logic sysclk_from_rtc_o, // system clock taken from rtc oscillator
   output logic preserve_mode_o // ram preservation mode active
);
   logic supply_good_s;
   logic ext_resetn_s;
   logic clock_pin_s;
   pm_state_type state;
   pm_state_type next_state;
   logic [31:0] count;
   logic [31:0] low_count;
   logic pin_reset_hit;
   logic dev_reset;
   logic [7:0] ie0;
   logic [7:0] ie1;
   logic [7:0] osc_ctl;
   logic [7:0] clk_sel;
   logic [7:0] misc;
   logic [7:0] status1;
   logic ready_pulse;
   logic ack;
   logic wr_hit;
   logic rd_hit;
   logic rd_clear;
   logic [7:0] rd_byte;

   rpm_sync u_sync_supply (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .d_i(supply_good_i),
      .q_o(supply_good_s)
   );
   rpm_sync u_sync_rst (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .d_i(ext_resetn_i),
      .q_o(ext_resetn_s)
   );
   rpm_sync u_sync_clk (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .d_i(clock_pin_i),
      .q_o(clock_pin_s)
   );

   // reset pin must stay low the least pulse time; shorter glitches are ignored
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         low_count <= 32'h0000_0000;
      end else if (ext_resetn_s) begin
         low_count <= 32'h0000_0000;
      end else if (low_count < 32'(reset_pulse_count)) begin
         low_count <= low_count + 32'h0000_0001;
      end
   end
   assign pin_reset_hit = !ext_resetn_s && (low_count >= 32'(reset_pulse_count - 1));

   always_comb begin
      next_state = state;
      unique case (state)
         st_por: begin
            if (supply_good_s && count >= 32'(power_on_count - 1)) begin
               next_state = st_startup;
            end
         end
         st_pin_reset: begin
            if (ext_resetn_s) begin
               next_state = st_startup;
            end
         end
         st_startup: begin
            if (count >= 32'(startup_count - 1)) begin
               next_state = st_normal;
            end
         end
         st_normal: begin
            if (!clock_pin_s && osc_ctl == osc_pin_value) begin
               next_state = st_armed;
            end
         end
         st_sync: next_state = st_normal;
         st_armed: begin
            if (clock_pin_s && clk_sel == clksel_rtc_value) begin
               next_state = st_preserve;
            end else if (clock_pin_s) begin
               next_state = st_normal;
            end
         end
         st_preserve: begin
            if (!clock_pin_s) begin
               next_state = st_normal;
            end
         end
      endcase
   end

   // reset sources take priority over every mode
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= st_por;
      end else if (!supply_good_s && state != st_por) begin
         state <= st_por;
      end else if (pin_reset_hit && state != st_por) begin
         state <= st_pin_reset;
      end else begin
         state <= next_state;
      end
   end

   // count restarts on each next_state transition (not on forced reset entries) and while supply is low in st_por
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count <= 32'h0000_0000;
      end else if (state != next_state || (state == st_por && !supply_good_s)) begin
         count <= 32'h0000_0000;
      end else if (count != 32'hffff_ffff) begin
         count <= count + 32'h0000_0001;
      end
   end

   assign dev_reset = (state == st_por) || (state == st_pin_reset);
   assign ready_pulse = (state == st_startup) && (next_state == st_normal);

   // avalon slave: one wait cycle per access, answer on the second cycle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read || avs_write) && !ack;
      end
   end
   assign avs_waitrequest = (avs_read || avs_write) && !ack;
   assign wr_hit = avs_write && ack && avs_byteenable[0];
   assign rd_hit = avs_read && ack;
   assign rd_clear = rd_hit && avs_address == int_status_1_offset;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ie0 <= ie0_reset;
         ie1 <= ie1_reset;
      end else if (dev_reset) begin
         ie0 <= ie0_reset;
         ie1 <= ie1_reset;
      end else if (wr_hit && avs_address == int_enable_0_offset) begin
         ie0 <= avs_writedata[7:0] | 8'hc6;
      end else if (wr_hit && avs_address == interrupt_enable_1_offset) begin
         ie1 <= avs_writedata[7:0] | ie1_fixed_mask;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         osc_ctl <= osc_reset;
         clk_sel <= clksel_reset;
         misc <= misc_reset;
      end else if (dev_reset) begin
         osc_ctl <= osc_reset;
         clk_sel <= clksel_reset;
         misc <= misc_reset;
      end else begin
         if (state == st_preserve && !clock_pin_s) begin
            clk_sel <= clksel_reset;
         end else if (wr_hit && avs_address == system_clock_select_offset) begin
            clk_sel <= avs_writedata[7:0];
         end
         if (wr_hit && avs_address == internal_osc_control_offset) begin
            osc_ctl <= avs_writedata[7:0];
         end
         if (wr_hit && avs_address == misc_control_offset) begin
            misc <= avs_writedata[7:0];
         end
      end
   end

   // status flags: a new event wins over the clear-on-read
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status1 <= 8'h00;
      end else if (dev_reset) begin
         status1 <= 8'h00;
      end else begin
         // only bits the read data showed are cleared, so an event after the capture survives
         status1[reset_done_bit] <= ready_pulse
            || (status1[reset_done_bit] && !(rd_clear && avs_readdata[reset_done_bit]));
         status1[timer1_bit] <= timer1_event_i
            || (status1[timer1_bit] && !(rd_clear && avs_readdata[timer1_bit]));
         status1[timer0_bit] <= timer0_event_i
            || (status1[timer0_bit] && !(rd_clear && avs_readdata[timer0_bit]));
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      unique case (avs_address)
         int_enable_0_offset: rd_byte = ie0;
         interrupt_enable_1_offset: rd_byte = ie1 | ie1_fixed_mask;
         int_status_1_rd_offset: rd_byte = status1;
         int_status_1_offset: rd_byte = status1;
         internal_osc_control_offset: rd_byte = osc_ctl;
         system_clock_select_offset: rd_byte = clk_sel;
         misc_control_offset: rd_byte = misc;
         power_state_offset: rd_byte = {5'b0_0000, preserve_mode_o, dev_reset,
            state == st_normal};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack) begin
         avs_readdata <= {24'h00_0000, rd_byte};
      end
   end

   // pin is registered so it never glitches on the host line
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         int_n_o <= 1'b1;
      end else if (dev_reset) begin
         int_n_o <= 1'b1;
      end else begin
         int_n_o <= !((status1[reset_done_bit] && ie1[reset_done_bit])
            || (status1[timer1_bit] && ie1[timer1_bit])
            || (status1[timer0_bit] && ie1[timer0_bit]));
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gpio_release_o <= 1'b1;
         in_reset_o <= 1'b1;
         int_osc_enable_o <= 1'b0;
         sysclk_from_rtc_o <= 1'b0;
         preserve_mode_o <= 1'b0;
      end else begin
         gpio_release_o <= dev_reset;
         in_reset_o <= dev_reset;
         int_osc_enable_o <= !dev_reset && state != st_preserve;
         sysclk_from_rtc_o <= state == st_preserve;
         preserve_mode_o <= state == st_preserve;
      end
   end
endmodule : reset_power_mode_control

// ### test/rpm_checker_asserts.sv
// assertion checker for reset, interrupt pin and power mode ports
module rpm_checker_asserts
   import rpm_pkg::*;
#(
   parameter int startup_count = 20 // start-up cycles
) (
   input wire logic clk_i, // clock
   input wire logic resetn_i, // reset
   input wire logic [7:0] avs_address, // addr
   input wire logic avs_read, // read
   input wire logic avs_write, // write
   input wire logic [31:0] avs_writedata, // wdata
   input wire logic [3:0] avs_byteenable, // be
   input wire logic [31:0] avs_readdata, // rdata
   input wire logic avs_waitrequest, // wait
   input wire logic int_n_o, // irq pin
   input wire logic gpio_release_o, // gpio
   input wire logic in_reset_o, // in reset
   input wire logic int_osc_enable_o, // osc
   input wire logic sysclk_from_rtc_o, // rtc clock
   input wire logic preserve_mode_o // preserve
);
   // slack covers the pin synchronisers and the registered pin
   localparam int exit_bound = startup_count + 20;
   logic ie_hit;
   assign ie_hit = !avs_waitrequest && avs_address == interrupt_enable_1_offset;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   property p_int_held; in_reset_o |-> int_n_o; endproperty
   a_int_held: assert property (p_int_held)
      else $error("irq low in reset");
   property p_gpio; in_reset_o |-> gpio_release_o; endproperty
   a_gpio: assert property (p_gpio)
      else $error("gpio driven in reset");
   property p_osc_stop; in_reset_o |-> !int_osc_enable_o; endproperty
   a_osc_stop: assert property (p_osc_stop)
      else $error("osc runs in reset");
   property p_rtc; preserve_mode_o |-> sysclk_from_rtc_o && !int_osc_enable_o; endproperty
   a_rtc: assert property (p_rtc)
      else $error("wrong clock in preservation");
   property p_exit; $fell(in_reset_o) |-> ##[1:exit_bound] !int_n_o; endproperty
   a_exit: assert property (p_exit)
      else $error("no irq after reset");
   property p_osc_first; $fell(int_n_o) && !preserve_mode_o |-> int_osc_enable_o; endproperty
   a_osc_first: assert property (p_osc_first)
      else $error("irq before osc start");
   property p_ones; avs_read && ie_hit |-> (avs_readdata[7:0] & ie1_fixed_mask) == 8'he3;
   endproperty
   a_ones: assert property (p_ones)
      else $error("unused enable bits not one");
   property p_mask;
      avs_write && ie_hit && avs_byteenable[0] && avs_writedata[7:0] == 8'h00 |-> ##2 int_n_o;
   endproperty
   a_mask: assert property (p_mask)
      else $error("irq with all masked");
   c_pres: cover property ($rose(preserve_mode_o));
   c_exit: cover property ($fell(in_reset_o));
   c_irq: cover property ($fell(int_n_o));
endmodule : rpm_checker_asserts

bind reset_power_mode_control rpm_checker_asserts #(.startup_count(startup_count)) i_chk (
   .clk_i(clk_i), .resetn_i(resetn_i), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .int_n_o(int_n_o),
   .gpio_release_o(gpio_release_o), .in_reset_o(in_reset_o),
   .int_osc_enable_o(int_osc_enable_o), .sysclk_from_rtc_o(sysclk_from_rtc_o),
   .preserve_mode_o(preserve_mode_o));

// ### test/rpm_host_model.sv
// host model: supply, reset and clock pins plus register bus master
module rpm_host_model
   import rpm_pkg::*;
(
   input wire logic clk_i, // clock
   input wire logic [31:0] avs_readdata_i, // rdata
   input wire logic avs_waitrequest_i, // wait
   input wire logic int_n_i, // irq pin
   output logic supply_good_o, // supply
   output logic ext_resetn_o, // reset pin
   output logic clock_pin_o, // clock pin
   output logic [7:0] avs_address_o, // addr
   output logic avs_read_o, // read
   output logic avs_write_o, // write
   output logic [31:0] avs_writedata_o, // wdata
   output logic [3:0] avs_byteenable_o // be
);
   initial begin
      supply_good_o = 1'b0;
      ext_resetn_o = 1'b1;
      clock_pin_o = 1'b1;
      avs_address_o = 8'h00;
      avs_read_o = 1'b0;
      avs_write_o = 1'b0;
      avs_writedata_o = 32'h0000_0000;
      avs_byteenable_o = 4'hf;
   end
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge clk_i);
      avs_address_o <= a;
      avs_read_o <= !w;
      avs_write_o <= w;
      avs_writedata_o <= {24'h00_0000, d};
      do @(posedge clk_i); while (avs_waitrequest_i !== 1'b0);
      q = avs_readdata_i[7:0];
      avs_read_o <= 1'b0;
      avs_write_o <= 1'b0;
   endtask : access
   task automatic power_up();
      @(posedge clk_i);
      supply_good_o <= 1'b1;
   endtask : power_up
   task automatic wait_ready(output int n);
      n = 0;
      while (int_n_i !== 1'b0) begin
         @(posedge clk_i);
         n++;
      end
   endtask : wait_ready
   task automatic reset_pulse(input int cycles);
      @(posedge clk_i);
      ext_resetn_o <= 1'b0;
      repeat (cycles) @(posedge clk_i);
      ext_resetn_o <= 1'b1;
   endtask : reset_pulse
   task automatic enter_preserve();
      logic [7:0] q;
      @(posedge clk_i);
      clock_pin_o <= 1'b0;
      access(1'b1, misc_control_offset, 8'h00, q);
      access(1'b1, internal_osc_control_offset, 8'h07, q);
      access(1'b1, internal_osc_control_offset, 8'h03, q);
      access(1'b1, system_clock_select_offset, 8'h05, q);
      @(posedge clk_i);
      clock_pin_o <= 1'b1;
   endtask : enter_preserve
   // the falling pin edge is the wake, as a slave-select line tied to the pin would give
   task automatic exit_preserve();
      logic [7:0] q;
      @(posedge clk_i);
      clock_pin_o <= 1'b0;
      access(1'b1, internal_osc_control_offset, 8'h06, q);
   endtask : exit_preserve
endmodule : rpm_host_model

// ### test/reset_power_mode_control_test.sv
// self-checking bench for reset and power mode control
module reset_power_mode_control_test
   import rpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int startup_delay = 20;
   localparam int t_por = 20;
   logic clk_i, resetn_i, sg, ern, cp, t0, t1, rd, wr, ws, irq_n, gpio, in_rst, osc, rtc, pres;
   logic [7:0] adr, q;
   logic [31:0] wd, rdata;
   logic [3:0] be;
   int errors, num_checks, n;
   always #5 clk_i = !clk_i;
   reset_power_mode_control #(.startup_count(startup_delay), .power_on_count(t_por),
      .reset_pulse_count(4)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .supply_good_i(sg),
      .ext_resetn_i(ern), .clock_pin_i(cp), .timer0_event_i(t0), .timer1_event_i(t1),
      .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(ws), .int_n_o(irq_n),
      .gpio_release_o(gpio), .in_reset_o(in_rst), .int_osc_enable_o(osc),
      .sysclk_from_rtc_o(rtc), .preserve_mode_o(pres));
   rpm_host_model i_host (.clk_i(clk_i), .avs_readdata_i(rdata), .avs_waitrequest_i(ws),
      .int_n_i(irq_n), .supply_good_o(sg), .ext_resetn_o(ern), .clock_pin_o(cp),
      .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr), .avs_writedata_o(wd),
      .avs_byteenable_o(be));
   task automatic close_out();
      if (errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
      i_host.access(w, a, d, q);
   endtask : rw
   task automatic pulse(input logic one);
      @(posedge clk_i);
      t0 <= !one;
      t1 <= one;
      @(posedge clk_i);
      t0 <= 1'b0;
      t1 <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : pulse
   task automatic test_power_on();
      repeat (30) @(posedge clk_i);
      chk({5'h00, in_rst, gpio, osc}, 8'h06);
      i_host.power_up();
      i_host.wait_ready(n);
      chk(8'(n >= t_por + startup_delay), 8'h01);
      rw(1'b0, int_status_1_rd_offset, 8'h00);
      chk(q & 8'h10, 8'h10);
      rw(1'b1, 8'h7f, 8'h00);
      rw(1'b0, interrupt_enable_1_offset, 8'h00);
      chk(q, 8'hff);
      rw(1'b0, int_enable_0_offset, 8'h00);
      chk(q & 8'h08, 8'h00);
   endtask : test_power_on
   task automatic test_masking();
      // reset-done alone enabled, then nothing enabled
      rw(1'b1, interrupt_enable_1_offset, 8'hf3);
      repeat (3) @(posedge clk_i);
      chk(8'(irq_n), 8'h00);
      rw(1'b1, interrupt_enable_1_offset, 8'he3);
      repeat (3) @(posedge clk_i);
      chk(8'(irq_n), 8'h01);
      rw(1'b0, int_status_1_offset, 8'h00);
      chk(q & 8'h10, 8'h10);
      rw(1'b1, interrupt_enable_1_offset, 8'h00);
      rw(1'b0, interrupt_enable_1_offset, 8'h00);
      chk(q, 8'he3);
      pulse(1'b0);
      pulse(1'b1);
      chk(8'(irq_n), 8'h01);
      rw(1'b0, int_status_1_offset, 8'h00);
      chk(q & 8'h1c, 8'h0c);
      for (int i = 0; i < 2; i++) begin
         rw(1'b1, interrupt_enable_1_offset, i ? 8'h08 : 8'h04);
         pulse(i[0]);
         chk(8'(irq_n), 8'h00);
         rw(1'b0, int_status_1_offset, 8'h00);
         chk(q & 8'h1c, i ? 8'h08 : 8'h04);
         repeat (3) @(posedge clk_i);
         chk(8'(irq_n), 8'h01);
      end
   endtask : test_masking
   task automatic test_pin_reset();
      rw(1'b1, interrupt_enable_1_offset, 8'h00);
      i_host.reset_pulse(2);
      repeat (6) @(posedge clk_i);
      chk(8'(in_rst), 8'h00);
      i_host.reset_pulse(12);
      chk({4'h0, in_rst, gpio, osc, irq_n}, 8'h0d);
      i_host.wait_ready(n);
      chk(8'(n >= startup_delay), 8'h01);
      rw(1'b0, interrupt_enable_1_offset, 8'h00);
      chk(q, 8'hff);
   endtask : test_pin_reset
   task automatic test_preserve();
      i_host.enter_preserve();
      repeat (8) @(posedge clk_i);
      chk({5'h00, pres, rtc, osc}, 8'h06);
      i_host.exit_preserve();
      repeat (8) @(posedge clk_i);
      chk({5'h00, pres, rtc, osc}, 8'h01);
      rw(1'b0, system_clock_select_offset, 8'h00);
      chk(q, 8'h00);
      rw(1'b0, power_state_offset, 8'h00);
      chk(q, 8'h01);
   endtask : test_preserve
   initial begin
      clk_i = 1'b0;
      resetn_i = 1'b0;
      t0 = 1'b0;
      t1 = 1'b0;
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      test_power_on();
      test_masking();
      test_pin_reset();
      test_preserve();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      close_out();
   end
endmodule : reset_power_mode_control_test
